// ### common/self_test_pkg.sv
// package for the drive self-test sequencer: codes, log layout, timing
// assumes a single 20 MHz clock domain
package self_test_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SHORT_LIMIT_S = 120;
  localparam longint unsigned SHORT_LIMIT_CYC = longint'(SHORT_LIMIT_S) * longint'(CLK_HZ);
  localparam int unsigned LOG_DEPTH = 20;
  localparam int unsigned LBA_W = 32;

  localparam logic [2:0] FC_SHORT = 3'h1;
  localparam logic [2:0] FC_EXTENDED = 3'h2;
  localparam logic [2:0] FC_ABORT_DEFAULT = 3'h4;
  localparam int unsigned FC_MSB = 7;
  localparam int unsigned FC_LSB = 5;

  localparam logic [3:0] RES_PASS = 4'h0;
  localparam logic [3:0] RES_ABORT_HOST = 4'h1;
  localparam logic [3:0] RES_ABORT_RESET = 4'h2;
  localparam logic [3:0] RES_FAIL = 4'h7;
  localparam logic [3:0] RES_IN_PROGRESS = 4'hf;

  localparam logic [7:0] SK_NOT_READY = 8'h02;
  localparam logic [7:0] ASC_NOT_READY = 8'h04;
  localparam logic [7:0] ASCQ_CAUSE_UNKNOWN = 8'h00;
  localparam logic [7:0] ASCQ_MANUAL_INTERVENTION = 8'h03;

  typedef enum logic [1:0] {SEG_ELECTRICAL, SEG_SERVO, SEG_SCAN} segment_t;

  typedef struct packed {
    logic [2:0] func_code;
    logic [3:0] result;
    logic [7:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] fru;
    logic [LBA_W-1:0] lba;
  } log_entry_t;

  typedef struct packed {
    logic [7:0] sense_key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] fru;
    logic [LBA_W-1:0] lba;
    logic lba_valid;
  } fail_info_t;

  typedef struct packed {
    logic spin_fail;
    logic speed_lock_fail;
    logic servo_lock_fail;
    logic config_read_fail;
    logic busy_format;
  } drive_health_t;

endpackage : self_test_pkg

// ### hdl/self_test_log.sv
// twenty-deep results log with insert-at-head and result rewrite
// assumes the caller commits it to non-volatile storage on commit pulses
`timescale 1ns/1ps
module self_test_log
  import self_test_pkg::*;
#(
  parameter int unsigned DEPTH = LOG_DEPTH
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic insert,
  input wire logic [2:0] insert_fc,
  input wire logic update,
  input wire logic [3:0] update_result,
  input wire self_test_pkg::fail_info_t update_fail,
  input wire logic [4:0] rd_index,
  output self_test_pkg::log_entry_t rd_entry,
  output logic [4:0] entry_count
);
  import self_test_pkg::*;

  typedef struct packed {
    log_entry_t [DEPTH-1:0] entry;
    logic [4:0] count;
    log_entry_t rd;
  } log_state_t;

  log_state_t state_q;
  log_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (insert)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
      begin
        state_d.entry[i] = state_q.entry[i-1]; // oldest falls off
      end
      state_d.entry[0] = '0;
      state_d.entry[0].func_code = insert_fc;
      state_d.entry[0].result = RES_IN_PROGRESS;
      if (state_q.count < 5'(DEPTH))
      begin
        state_d.count = state_q.count + 5'h01;
      end
    end
    else if (update)
    begin
      state_d.entry[0].result = update_result;
      if (update_result != RES_PASS && update_result != RES_ABORT_HOST && update_result != RES_ABORT_RESET)
      begin
        state_d.entry[0].sense_key = update_fail.sense_key;
        state_d.entry[0].asc = update_fail.asc;
        state_d.entry[0].ascq = update_fail.ascq;
        state_d.entry[0].fru = update_fail.fru;
        state_d.entry[0].lba = update_fail.lba_valid ? update_fail.lba : '1;
      end
    end
    state_d.rd = (rd_index < 5'(DEPTH)) ? state_q.entry[rd_index] : '0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= '0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
    end
  end

  assign rd_entry = state_q.rd;
  assign entry_count = state_q.count;

  a_log_head_init: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && insert |=> state_q.entry[0].result == RES_IN_PROGRESS)
    else $error("new log block not marked in progress");

  a_log_shift: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && insert |=> state_q.entry[1] == $past(state_q.entry[0]))
    else $error("log did not shift on insert");

  a_log_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    entry_count <= 5'(DEPTH))
    else $error("log count exceeded depth");

endmodule : self_test_log

// ### hdl/drive_self_test.sv
// drive self-test sequencer: command decode, segment run, abort, log
// assumes segment engines report done/unrecovered error; inputs synchronous
`timescale 1ns/1ps
module drive_self_test
  import self_test_pkg::*;
#(
  parameter longint unsigned SHORT_LIMIT = SHORT_LIMIT_CYC,
  parameter logic [2:0] FC_ABORT = FC_ABORT_DEFAULT,
  parameter logic [15:0] EXT_DURATION_S = 16'h0e10
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic diag_cmd_valid,
  input wire logic [7:0] diag_cmd_byte1,
  input wire logic tur_req,
  output logic tur_not_ready,
  output logic [7:0] tur_sense_key,
  output logic [7:0] tur_asc,
  output logic [7:0] tur_ascq,
  input wire self_test_pkg::drive_health_t health,
  input wire logic bus_reset,
  input wire logic bus_device_reset,
  output logic seg_start,
  output self_test_pkg::segment_t seg_sel,
  output logic seg_full_scan,
  input wire logic seg_done,
  input wire logic seg_unrecovered_err,
  input wire self_test_pkg::fail_info_t seg_fail_info,
  output logic test_busy,
  output logic cmd_refused,
  output logic nv_commit,
  output logic [15:0] ext_duration,
  input wire logic [4:0] log_rd_index,
  output self_test_pkg::log_entry_t log_rd_entry,
  output logic [4:0] log_count
);
  import self_test_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_LAUNCH, ST_WAIT, ST_FINISH} run_state_t;

  typedef struct packed {
    run_state_t run;
    segment_t seg;
    logic extended;
    logic [39:0] timer;
    logic [3:0] result;
    fail_info_t fail;
    logic tur_nr;
    logic [7:0] tur_ascq;
    logic refused;
    logic commit;
  } core_state_t;

  core_state_t state_q;
  core_state_t state_d;
  logic [2:0] fc;
  logic not_ready;
  logic any_reset;
  logic log_insert;
  logic log_update;

  assign fc = diag_cmd_byte1[FC_MSB:FC_LSB];
  assign not_ready = health.spin_fail | health.speed_lock_fail | health.servo_lock_fail | health.config_read_fail;
  assign any_reset = bus_reset | bus_device_reset;

  always_comb
  begin
    state_d = state_q;
    state_d.commit = 1'b0;
    state_d.refused = 1'b0;
    log_insert = 1'b0;
    log_update = 1'b0;
    if (tur_req)
    begin
      state_d.tur_nr = not_ready;
      state_d.tur_ascq = health.config_read_fail ? ASCQ_MANUAL_INTERVENTION : ASCQ_CAUSE_UNKNOWN;
    end
    case (state_q.run)
      ST_IDLE:
      begin
        if (diag_cmd_valid && (fc == FC_SHORT || fc == FC_EXTENDED))
        begin
          // refuse rather than rely on the host checking readiness
          if (not_ready || health.busy_format)
          begin
            state_d.refused = 1'b1;
          end
          else
          begin
            log_insert = 1'b1;
            state_d.commit = 1'b1;
            state_d.extended = (fc == FC_EXTENDED);
            state_d.seg = SEG_ELECTRICAL;
            state_d.timer = '0;
            state_d.result = RES_PASS;
            state_d.run = ST_LAUNCH;
          end
        end
      end
      ST_LAUNCH, ST_WAIT:
      begin
        state_d.timer = state_q.timer + 40'h1;
        if (diag_cmd_valid && (fc == FC_SHORT || fc == FC_EXTENDED))
        begin
          state_d.refused = 1'b1;
        end
        state_d.run = ST_WAIT;
        if (any_reset)
        begin
          state_d.result = RES_ABORT_RESET;
          state_d.run = ST_FINISH;
        end
        else if (diag_cmd_valid && fc == FC_ABORT)
        begin
          state_d.result = RES_ABORT_HOST;
          state_d.run = ST_FINISH;
        end
        else if (!state_q.extended && state_q.timer >= 40'(SHORT_LIMIT - 2))
        begin
          state_d.run = ST_FINISH; // partial scan simply stops at the limit
        end
        else if (state_q.run == ST_WAIT && seg_done)
        begin
          if (seg_unrecovered_err)
          begin
            state_d.result = RES_FAIL;
            state_d.fail = seg_fail_info;
            state_d.run = ST_FINISH;
          end
          else if (state_q.seg == SEG_SCAN)
          begin
            state_d.run = ST_FINISH;
          end
          else
          begin
            state_d.seg = (state_q.seg == SEG_ELECTRICAL) ? SEG_SERVO : SEG_SCAN;
            state_d.run = ST_LAUNCH;
          end
        end
      end
      ST_FINISH:
      begin
        log_update = 1'b1;
        state_d.commit = 1'b1;
        state_d.run = ST_IDLE;
      end
      default:
      begin
        state_d.run = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= '{run: ST_IDLE, seg: SEG_ELECTRICAL, default: '0};
    end
    else if (clk_en)
    begin
      state_q <= state_d;
    end
  end

  self_test_log #(
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .insert(log_insert),
    .insert_fc(fc),
    .update(log_update),
    .update_result(state_q.result),
    .update_fail(state_q.fail),
    .rd_index(log_rd_index),
    .rd_entry(log_rd_entry),
    .entry_count(log_count)
  );

  assign tur_not_ready = state_q.tur_nr;
  assign tur_sense_key = state_q.tur_nr ? SK_NOT_READY : 8'h00;
  assign tur_asc = state_q.tur_nr ? ASC_NOT_READY : 8'h00;
  assign tur_ascq = state_q.tur_nr ? state_q.tur_ascq : 8'h00;
  assign seg_start = (state_q.run == ST_LAUNCH);
  assign seg_sel = state_q.seg;
  assign seg_full_scan = state_q.extended;
  assign test_busy = (state_q.run != ST_IDLE);
  assign cmd_refused = state_q.refused;
  assign nv_commit = state_q.commit;
  assign ext_duration = EXT_DURATION_S;

  sequence s_seg_done_ok;
    seg_done && !seg_unrecovered_err && !any_reset && !(diag_cmd_valid && fc == FC_ABORT);
  endsequence

  a_tur_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && tur_req && not_ready |=> tur_sense_key == SK_NOT_READY && tur_asc == ASC_NOT_READY)
    else $error("not ready code missing");

  a_seg_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && state_q.run == ST_WAIT && state_q.seg == SEG_ELECTRICAL
    && (state_q.extended || state_q.timer < 40'(SHORT_LIMIT - 2))) and s_seg_done_ok
    |=> seg_sel == SEG_SERVO && seg_start)
    else $error("servo segment did not follow electrical");

  a_reset_abort: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && test_busy && state_q.run != ST_FINISH && any_reset
    |=> state_q.run == ST_FINISH && state_q.result == RES_ABORT_RESET)
    else $error("reset abort not recorded as 02");

  a_host_abort: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && test_busy && state_q.run != ST_FINISH && !any_reset && diag_cmd_valid && fc == FC_ABORT
    |=> state_q.result == RES_ABORT_HOST)
    else $error("host abort not recorded as 01");

  a_finish_commit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && state_q.run == ST_FINISH |=> nv_commit && !test_busy)
    else $error("finish without commit");

  a_busy_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && (state_q.run == ST_WAIT || state_q.run == ST_LAUNCH) && diag_cmd_valid && fc == FC_SHORT
    |=> cmd_refused)
    else $error("second start not refused");

  a_short_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !state_q.extended && test_busy |-> state_q.timer < 40'(SHORT_LIMIT))
    else $error("short test overran its limit");

  a_fail_recovered: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && state_q.run == ST_WAIT) and s_seg_done_ok |=> state_q.result == RES_PASS)
    else $error("recovered error counted as failure");

endmodule : drive_self_test

// ### verification/self_test_host_model.sv
// host initiator model: diagnostic start and abort, unit-ready polling
// assumes the drive samples its command inputs on ref_clk rising edges
`timescale 1ns/1ps
module self_test_host_model(
  input wire logic ref_clk,
  input wire logic tur_not_ready,
  output logic diag_cmd_valid,
  output logic [7:0] diag_cmd_byte1,
  output logic tur_req
);
  initial
  begin
    diag_cmd_valid = 1'b0;
    diag_cmd_byte1 = 8'h00;
    tur_req = 1'b0;
  end

  task automatic send_cmd(input logic [2:0] fc);
    @(posedge ref_clk);
    diag_cmd_valid <= 1'b1;
    diag_cmd_byte1 <= {fc, 5'h0b};
    @(posedge ref_clk);
    diag_cmd_valid <= 1'b0;
    diag_cmd_byte1 <= {~fc, 5'h14};
  endtask : send_cmd

  task automatic ask_ready(output logic ok);
    @(posedge ref_clk);
    tur_req <= 1'b1;
    @(posedge ref_clk);
    tur_req <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    ok = !tur_not_ready;
  endtask : ask_ready

  task automatic start_test(input logic [2:0] fc);
    logic ok;
    ask_ready(ok);
    if (ok) send_cmd(fc);
  endtask : start_test
endmodule : self_test_host_model

// ### verification/drive_self_test_test.sv
// self-checking bench for the drive self-test sequencer with a log model
// assumes the host model file; a segment engine responder lives here
`timescale 1ns/1ps
module drive_self_test_test;
  import self_test_pkg::*;
  localparam longint unsigned SIM_LIMIT = 200;
  logic ref_clk, sys_rst, clk_en, tur_req, tur_not_ready, bus_reset, bus_device_reset;
  logic diag_cmd_valid, seg_start, seg_full_scan, seg_done, seg_unrecovered_err;
  logic test_busy, cmd_refused, nv_commit, stall;
  logic [7:0] diag_cmd_byte1, tur_sense_key, tur_asc, tur_ascq;
  logic [15:0] ext_duration;
  logic [4:0] log_rd_index, log_count;
  logic [31:0] seed = 32'he50dfe52;
  drive_health_t health;
  segment_t seg_sel;
  fail_info_t seg_fail_info, info;
  log_entry_t log_rd_entry;
  log_entry_t mdl[$];
  int num_errors = 0;
  int tests_run = 0;
  int fail_at = 3;
  int seg_code = 0;
  int modes[6] = '{0, 1, 1, 2, 3, 6};

  drive_self_test #(.SHORT_LIMIT(SIM_LIMIT), .FC_ABORT(FC_ABORT_DEFAULT)) i_dut (
    .ref_clk, .sys_rst, .clk_en, .diag_cmd_valid, .diag_cmd_byte1, .tur_req, .tur_not_ready,
    .tur_sense_key, .tur_asc, .tur_ascq, .health, .bus_reset, .bus_device_reset, .seg_start,
    .seg_sel, .seg_full_scan, .seg_done, .seg_unrecovered_err, .seg_fail_info, .test_busy,
    .cmd_refused, .nv_commit, .ext_duration, .log_rd_index, .log_rd_entry, .log_count
  );
  self_test_host_model i_host (.ref_clk, .tur_not_ready, .diag_cmd_valid, .diag_cmd_byte1, .tur_req);

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // segment engine: answers each launch after a random delay, unless stall is set or test_busy has dropped
  initial
  forever
  begin
    @(posedge ref_clk);
    if (seg_start === 1'b1)
    begin
      seg_code = seg_code * 4 + int'(seg_sel) + 1;
      repeat (4 + rnd() % 8) @(posedge ref_clk);
      if (!stall && test_busy === 1'b1)
      begin
        seg_done <= 1'b1;
        seg_unrecovered_err <= (int'(seg_sel) == fail_at);
        seg_fail_info <= info;
        @(posedge ref_clk);
        seg_done <= 1'b0;
        seg_unrecovered_err <= seed[3];
        seg_fail_info <= ~info;
      end
    end
  end

  task automatic check_log();
    check("log_count", mdl.size(), log_count);
    foreach (mdl[i])
    begin
      @(posedge ref_clk);
      log_rd_index <= 5'(i);
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("log_head", {mdl[i].func_code, mdl[i].result}, {log_rd_entry.func_code, log_rd_entry.result});
      if (mdl[i].result == RES_FAIL) check("log_fail", mdl[i][63:0], log_rd_entry[63:0]);
    end
    @(posedge ref_clk);
    log_rd_index <= 5'h00;
  endtask : check_log

  task automatic run_test(input logic [2:0] fc, input int mode);
    log_entry_t e;
    int n;
    int exp;
    e = '0;
    e.func_code = fc;
    e.result = RES_IN_PROGRESS;
    mdl.push_front(e);
    if (mdl.size() > LOG_DEPTH) mdl.pop_back();
    info = {rnd(), rnd(), seed[5]};
    fail_at = (mode == 1) ? int'(rnd() % 3) : 3;
    stall = (mode == 4);
    seg_code = 0;
    i_host.start_test(fc);
    @(negedge ref_clk);
    check("launch", 3'b111, {seg_start, nv_commit, test_busy});
    check("full_scan", fc == FC_EXTENDED, seg_full_scan);
    repeat (2) @(negedge ref_clk);
    check("fresh_block", {fc, RES_IN_PROGRESS}, {log_rd_entry.func_code, log_rd_entry.result});
    if (mode == 2) i_host.send_cmd(FC_ABORT_DEFAULT);
    if (mode == 5)
    begin
      i_host.send_cmd(FC_SHORT);
      @(negedge ref_clk);
      check("busy_refused", 1, cmd_refused);
    end
    if (mode == 3 || mode == 6)
    begin
      @(posedge ref_clk);
      {bus_reset, bus_device_reset} <= (mode == 3) ? 2'b10 : 2'b01;
      @(posedge ref_clk);
      {bus_reset, bus_device_reset} <= 2'b00;
    end
    n = 0;
    while (test_busy !== 1'b0 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("finished_in_time", 1, n < 5000);
    check("finish_commit", 1, nv_commit);
    if (mode == 4) check("short_limit", 1, n <= SIM_LIMIT);
    exp = (mode == 2) ? 1 : (mode == 3 || mode == 6) ? 2 : (fail_at < 3) ? 7 : 0;
    mdl[0].result = 4'(exp);
    if (exp == 7) mdl[0][63:0] = {info[64:33], info.lba_valid ? info.lba : 32'hffffffff};
    if (mode < 2 || mode == 5)
    begin
      n = 0;
      for (int j = 0; j <= (fail_at < 3 ? fail_at : 2); j++) n = n * 4 + j + 1;
      check("segments", n, seg_code);
    end
    check_log();
  endtask : run_test

  initial
  begin
    logic ok;
    logic [24:0] q;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    stall = 1'b0;
    health = '0;
    bus_reset = 1'b0;
    bus_device_reset = 1'b0;
    seg_done = 1'b0;
    seg_unrecovered_err = 1'b0;
    seg_fail_info = '0;
    info = '0;
    log_rd_index = 5'h00;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check("idle", 6'h00, {test_busy, log_count});
    check("ext_duration", 16'h0e10, ext_duration);
    for (int b = 0; b < 5; b++)
    begin
      @(posedge ref_clk);
      health <= drive_health_t'(5'(1 << b));
      i_host.ask_ready(ok);
      q = {1'b1, SK_NOT_READY, ASC_NOT_READY, (b == 1) ? ASCQ_MANUAL_INTERVENTION : ASCQ_CAUSE_UNKNOWN};
      // format busy alone is no not-ready fault
      if (b == 0) q = 25'h0;
      check("tur", q, {tur_not_ready, tur_sense_key, tur_asc, tur_ascq});
      i_host.send_cmd(FC_SHORT);
      @(negedge ref_clk);
      check("not_ready_refused", 1, cmd_refused);
    end
    // clock enable low: polls and commands leave all state untouched
    @(posedge ref_clk);
    clk_en <= 1'b0;
    health <= '0;
    i_host.ask_ready(ok);
    check("frozen_tur", 1, tur_not_ready);
    i_host.send_cmd(FC_SHORT);
    @(negedge ref_clk);
    check("frozen_idle", 3'b000, {test_busy, cmd_refused, nv_commit});
    check("frozen_log", 0, log_count);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    @(posedge ref_clk);
    health <= '0;
    i_host.ask_ready(ok);
    check("tur_ok", 25'h0, {tur_not_ready, tur_sense_key, tur_asc, tur_ascq});
    check_log();
    for (int k = 0; k < 12; k++) run_test(k % 2 ? FC_EXTENDED : FC_SHORT, modes[k / 2]);
    run_test(FC_SHORT, 5);
    run_test(FC_SHORT, 4);
    repeat (10) run_test(FC_EXTENDED, 2);
    complete_run();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    $display("watchdog expired");
    complete_run();
  end
endmodule : drive_self_test_test
